// File: verilog/cop_cfg.svh
// constants of the compare output path: register offsets, field positions, reset values
// assumes a 32-bit classic wishbone slave with byte addresses, one register per word
`ifndef COP_CFG_SVH
`define COP_CFG_SVH

// register byte offsets
`define COP_OFS_DTC      8'h00
`define COP_OFS_CMD      8'h04
`define COP_OFS_COMPARE_STATUS_REG  8'h08
`define COP_OFS_MODULATION_CONTROL_REG   8'h0C
`define COP_OFS_TRAPEN   8'h10
`define COP_OFS_PSL      8'h14

// dead_time_control_reg fields
`define COP_DTC_LEN_LSB  0
`define COP_DTC_EN_LSB   8

// timer_command_reg bits (write-only, read as zero)
`define COP_CMD_DEAD_TIME_RESET_CMD    0
`define COP_CMD_STR      1
`define COP_CMD_STD      2

// compare_status_reg fields
`define COP_CS_ST_LSB    0
`define COP_CS_DTA_LSB   4
`define COP_CS_REQ       7
`define COP_CS_SEL_LSB   8

// modulation_control_reg fields
`define COP_MC_PRI_LSB   0
`define COP_MC_MCM       7
`define COP_MC_SEC_LSB   8

// reset values
`define COP_RST_DTLEN    8'h00
`define COP_RST_DTEN     3'h0
`define COP_RST_SEL      6'h00
`define COP_RST_MODEN    6'h00
`define COP_RST_TRAPEN   6'h00
`define COP_RST_PSL      6'h00

`endif

// File: verilog/cop_pkg.sv
// types of the compare output path
// assumes the primary timer core and the trap logic share the module clock
package cop_pkg;

    // primary timer status, all on the module clock
    typedef struct packed {
        logic       tick;          // one-cycle pulse per primary timer clock
        logic       run;           // primary_run_bit
        logic       dir;           // count_direction, 1 = down
        logic       period_match;
        logic       one_match;
        logic [2:0] cmp_match;     // per channel equal-compare
    } cop_tmr_t;

    // other modulation sources
    typedef struct packed {
        logic       sec_cmp;       // secondary_compare_signal, active high
        logic [5:0] pattern;       // multichannel_pattern_bit per output
        logic       trap;          // trap_state
    } cop_mod_src_t;

endpackage : cop_pkg

// File: verilog/cop_path.sv
// compare output path: state bits, dead-time, state selection, modulation, passive levels
// assumes timer and modulation inputs come from logic on CLK_SYS_I; classic wishbone master
`timescale 1ns/1ps
`include "cop_cfg.svh"

module cop_path #(
    parameter int DT_W = 8
) (
    // clock and reset
    input  wire logic                  CLK_SYS_I,
    input  wire logic                  RESET_N_I,
    // wishbone slave
    input  wire logic                  WB_CYC_I,
    input  wire logic                  WB_STB_I,
    input  wire logic                  WB_WE_I,
    input  wire logic [7:0]            WB_ADR_I,
    input  wire logic [3:0]            WB_SEL_I,
    input  wire logic [31:0]           WB_DAT_I,
    output logic      [31:0]           WB_DAT_O,
    output logic                       WB_ACK_O,
    // timer and modulation sources
    input  wire cop_pkg::cop_tmr_t     TMR_I,
    input  wire cop_pkg::cop_mod_src_t MOD_I,
    // output pins to gate drivers
    output logic      [2:0]            HS_OUT_O,
    output logic      [2:0]            LS_OUT_O
);
    import cop_pkg::*;


    // software-written configuration
    logic [DT_W-1:0] dt_len_ff;
    logic [2:0]      dt_en_ff;
    logic [5:0]      sel_ff;
    logic [5:0]      pri_en_ff;
    logic [5:0]      sec_en_ff;
    logic            mcm_en_ff;
    logic [5:0]      trap_en_ff;

    // passive levels: shadow written by software, active copy used at the pins
    logic [5:0]      psl_shadow_ff;
    logic [5:0]      psl_ff;
    logic            req_ff;

    // channel state and dead-time bookkeeping
    logic [2:0]      st_ff;
    logic [2:0]      seen_ff;
    logic [DT_W-1:0] cnt_ff [3];
    logic [2:0]      dt_busy;

    // combinational signal path, state bit to modulated output
    logic [2:0]      direct_sig;
    logic [2:0]      inv_sig;
    logic [5:0]      cmp_sig;
    logic [5:0]      mod_sig;

    // bus side
    logic            ack_ff;
    logic [31:0]     rdat_ff;
    logic [31:0]     nxt_rdat;
    logic [31:0]     wmask;
    logic [31:0]     wdat;
    logic            wr_acc;

    // one-cycle strobes decoded from the bus, and the timer's transfer condition (a level while stopped)
    logic            shadow_xfer;
    logic            dt_reset;
    logic            req_set;
    logic            req_clr;

    // a write lands on the edge where ack is sampled high by the master;
    // taking it any earlier would let a write land twice if the master
    // stretched its strobe, so the ack edge is the only commit point
    assign wr_acc = WB_CYC_I & WB_STB_I & WB_WE_I & ack_ff;
    assign wmask  = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    assign wdat   = WB_DAT_I & wmask;


    // timer_command_reg strobes: one-shot, nothing is stored
    // several command bits may be written in one access; STR and STD together leave the request set
    assign dt_reset = wr_acc && (WB_ADR_I == `COP_OFS_CMD) && wdat[`COP_CMD_DEAD_TIME_RESET_CMD];
    assign req_set  = wr_acc && (WB_ADR_I == `COP_OFS_CMD) && wdat[`COP_CMD_STR];
    assign req_clr  = wr_acc && (WB_ADR_I == `COP_OFS_CMD) && wdat[`COP_CMD_STD];


    // primary shadow transfer condition
    // a stopped timer transfers on every tick, so software sees its
    // passive-level writes take effect on the next tick while nothing runs
    assign shadow_xfer = !TMR_I.run
                       || (req_ff && ((TMR_I.period_match && !TMR_I.dir)
                                   || (TMR_I.one_match && TMR_I.dir)));


    // bus acknowledge: one wait cycle, then ack for exactly one cycle
    // the wait cycle buys a registered read path at the cost of bus rate;
    // the master must drop its strobe after ack before a new access
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            ack_ff <= 1'b0;
        else
            ack_ff <= WB_CYC_I & WB_STB_I & !ack_ff;
    end


    // read mux; unmapped addresses and the command register read zero
    // the passive-level read shows the copy in use, not the shadow
    always_comb
    begin
        nxt_rdat = 32'h0000_0000;
        if (WB_ADR_I == `COP_OFS_DTC)
        begin
            nxt_rdat[`COP_DTC_LEN_LSB +: DT_W] = dt_len_ff;
            nxt_rdat[`COP_DTC_EN_LSB +: 3]     = dt_en_ff;
        end
        else if (WB_ADR_I == `COP_OFS_COMPARE_STATUS_REG)
        begin
            nxt_rdat[`COP_CS_ST_LSB +: 3]  = st_ff;
            nxt_rdat[`COP_CS_DTA_LSB +: 3] = dt_busy;
            nxt_rdat[`COP_CS_REQ]          = req_ff;
            nxt_rdat[`COP_CS_SEL_LSB +: 6] = sel_ff;
        end
        else if (WB_ADR_I == `COP_OFS_MODULATION_CONTROL_REG)
        begin
            nxt_rdat[`COP_MC_PRI_LSB +: 6] = pri_en_ff;
            nxt_rdat[`COP_MC_MCM]          = mcm_en_ff;
            nxt_rdat[`COP_MC_SEC_LSB +: 6] = sec_en_ff;
        end
        else if (WB_ADR_I == `COP_OFS_TRAPEN)
            nxt_rdat[5:0] = trap_en_ff;
        else if (WB_ADR_I == `COP_OFS_PSL)
            nxt_rdat[5:0] = psl_ff;
    end


    // read data is captured with the ack so it stands stable in the ack cycle
    // status seen is the value one cycle before the ack edge
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            rdat_ff <= 32'h0000_0000;
        else if (WB_CYC_I && WB_STB_I && !ack_ff)
            rdat_ff <= nxt_rdat;
    end

    assign WB_ACK_O = ack_ff;
    assign WB_DAT_O = rdat_ff;


    // software-written control registers
    // byte lanes 0 and 1 carry all fields; lanes 2 and 3 are ignored
    // a new dead-time length only acts on the next counter load
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            dt_len_ff     <= DT_W'(`COP_RST_DTLEN);
            dt_en_ff      <= `COP_RST_DTEN;
            sel_ff        <= `COP_RST_SEL;
            pri_en_ff     <= `COP_RST_MODEN;
            sec_en_ff     <= `COP_RST_MODEN;
            mcm_en_ff     <= 1'b0;
            trap_en_ff    <= `COP_RST_TRAPEN;
        end
        else if (wr_acc)
        begin
            if (WB_ADR_I == `COP_OFS_DTC)
            begin
                if (WB_SEL_I[0])
                    dt_len_ff <= WB_DAT_I[`COP_DTC_LEN_LSB +: DT_W];
                if (WB_SEL_I[1])
                    dt_en_ff  <= WB_DAT_I[`COP_DTC_EN_LSB +: 3];
            end
            else if (WB_ADR_I == `COP_OFS_COMPARE_STATUS_REG)
            begin
                if (WB_SEL_I[1])
                    sel_ff <= WB_DAT_I[`COP_CS_SEL_LSB +: 6];
            end
            else if (WB_ADR_I == `COP_OFS_MODULATION_CONTROL_REG)
            begin
                if (WB_SEL_I[0])
                begin
                    pri_en_ff <= WB_DAT_I[`COP_MC_PRI_LSB +: 6];
                    mcm_en_ff <= WB_DAT_I[`COP_MC_MCM];
                end
                if (WB_SEL_I[1])
                    sec_en_ff <= WB_DAT_I[`COP_MC_SEC_LSB +: 6];
            end
            else if (WB_ADR_I == `COP_OFS_TRAPEN)
            begin
                if (WB_SEL_I[0])
                    trap_en_ff <= WB_DAT_I[5:0];
            end
        end
    end


    // passive level shadow: software writes only the shadow copy
    // this keeps a polarity change from glitching a pin mid-period
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            psl_shadow_ff <= `COP_RST_PSL;
        else if (wr_acc && (WB_ADR_I == `COP_OFS_PSL) && WB_SEL_I[0])
            psl_shadow_ff <= WB_DAT_I[5:0];
    end


    // active passive levels follow the shadow on a transfer tick
    // all six bits move together so a leg never shows mixed polarity
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            psl_ff <= `COP_RST_PSL;
        else if (TMR_I.tick && shadow_xfer)
            psl_ff <= psl_shadow_ff;
    end


    // transfer request: a software set in the same cycle beats the hardware clear
    // so a request made right at a transfer is not lost for a whole period
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            req_ff <= 1'b0;
        else if (req_set)
            req_ff <= 1'b1;
        else if (req_clr || (TMR_I.tick && shadow_xfer))
            req_ff <= 1'b0;
    end


    // channel state bits switch on the timer clock after a compare match
    // a stopped timer freezes them; only compare mode rules are modelled
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            st_ff <= 3'h0;
        else if (TMR_I.tick && TMR_I.run)
        begin
            for (int c = 0; c < 3; c++)
            begin
                if (TMR_I.cmp_match[c])
                    st_ff[c] <= !TMR_I.dir;
            end
        end
    end


    // dead-time counters, one per channel, sharing one length
    // seen_ff remembers the state the last dead-time was started for;
    // a mismatch while counting is held off, so an early toggle cannot
    // stretch the dead-time, but it is taken as soon as the count ends
    // limitation: a length of zero leaves only the one clock of the pending change as dead-time
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            seen_ff <= 3'h0;
            for (int c = 0; c < 3; c++)
                cnt_ff[c] <= '0;
        end
        else
        begin
            for (int c = 0; c < 3; c++)
            begin
                if (dt_reset || !dt_en_ff[c])
                begin
                    // forced or disabled: passive, state followed at once
                    cnt_ff[c]  <= '0;
                    seen_ff[c] <= st_ff[c];
                end
                else if (cnt_ff[c] != '0)
                begin
                    // changes are held off until the running dead-time ends
                    if (TMR_I.tick)
                        cnt_ff[c] <= cnt_ff[c] - 1'b1;
                end
                else if (st_ff[c] != seen_ff[c])
                begin
                    cnt_ff[c]  <= dt_len_ff;
                    seen_ff[c] <= st_ff[c];
                end
            end
        end
    end


    // a pending change also masks: the edge toward active waits for the load
    // both signals go passive at once, so the active-to-passive edge
    // is never delayed while the opposite edge waits for the count
    always_comb
    begin
        for (int c = 0; c < 3; c++)
        begin
            dt_busy[c]    = (cnt_ff[c] != '0) || (dt_en_ff[c] && (st_ff[c] != seen_ff[c]));
            direct_sig[c] = st_ff[c] && !dt_busy[c];
            inv_sig[c]    = !st_ff[c] && !dt_busy[c];
        end
    end


    // state selection and modulation for all six outputs, even = high side
    // the trap term sits last so it overrides every other source
    // with no source enabled the output stays passive
    always_comb
    begin
        for (int y = 0; y < 6; y++)
        begin
            // select 1: active after the compare point, 0: before it
            cmp_sig[y] = sel_ff[y] ? direct_sig[y/2] : inv_sig[y/2];
            mod_sig[y] = (pri_en_ff[y] || sec_en_ff[y] || mcm_en_ff)
                      && (!pri_en_ff[y] || cmp_sig[y])
                      && (!sec_en_ff[y] || MOD_I.sec_cmp)
                      && (!mcm_en_ff || MOD_I.pattern[y])
                      && !(MOD_I.trap && trap_en_ff[y]);
        end
    end


    // level selection into output flops; passive levels should switch drivers off
    // registering the pins adds one cycle of latency but keeps them glitch-free
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            HS_OUT_O <= 3'h0;
            LS_OUT_O <= 3'h0;
        end
        else
        begin
            for (int c = 0; c < 3; c++)
            begin
                HS_OUT_O[c] <= psl_ff[2*c] ^ mod_sig[2*c];
                LS_OUT_O[c] <= psl_ff[2*c+1] ^ mod_sig[2*c+1];
            end
        end
    end

endmodule : cop_path

// File: tb/cop_gate_drv.sv
// model of the gate drivers behind the six pins
// assumes off_lvl_i is the pin level that turns a switch off
`timescale 1ns/1ps
module cop_gate_drv
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // pins
    input  wire logic [2:0] hs_i,
    input  wire logic [2:0] ls_i,
    input  wire logic       off_lvl_i,
    // shoot-through cycles seen
    output logic      [7:0] overlap_cnt_o
);
    logic [2:0] hs_on;
    logic [2:0] ls_on;
    // the passive level is the off level, so passive pins leave the switches open
    assign hs_on = hs_i ^ {3{off_lvl_i}};
    assign ls_on = ls_i ^ {3{off_lvl_i}};
    // both switches of a leg on shorts the supply; the model lets it happen and counts it
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            overlap_cnt_o <= 8'h00;
        else if (|(hs_on & ls_on))
            overlap_cnt_o <= overlap_cnt_o + 8'h01;
    end
endmodule : cop_gate_drv

// File: tb/cop_path_checker.sv
// port assertions of the compare output path
// assumes full lanes 0 and 1 on enable writes
`timescale 1ns/1ps
`include "cop_cfg.svh"
module cop_path_checker #(
    parameter int DT_W = 8
) (
    // clock, reset, bus
    input wire logic                  CLK_SYS_I,
    input wire logic                  RESET_N_I,
    input wire logic                  WB_CYC_I,
    input wire logic                  WB_STB_I,
    input wire logic                  WB_WE_I,
    input wire logic [7:0]            WB_ADR_I,
    input wire logic [3:0]            WB_SEL_I,
    input wire logic [31:0]           WB_DAT_I,
    input wire logic [31:0]           WB_DAT_O,
    input wire logic                  WB_ACK_O,
    // sources and pins
    input wire cop_pkg::cop_tmr_t     TMR_I,
    input wire cop_pkg::cop_mod_src_t MOD_I,
    input wire logic [2:0]            HS_OUT_O,
    input wire logic [2:0]            LS_OUT_O
);
    logic [13:0] mc_ff;
    logic [5:0]  te_ff;
    logic        wr;
    logic        rd;
    logic        mc_off;
    logic        sec_only;
    // bus decode and the enable patterns the rules need
    assign wr       = WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I;
    assign rd       = WB_ACK_O && !WB_WE_I;
    assign mc_off   = mc_ff == 14'h0000;
    assign sec_only = mc_ff == 14'h3F00 && !MOD_I.trap;
    // mirrors land on the ack edge, same as the design's registers
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            mc_ff <= 14'h0000;
            te_ff <= 6'h00;
        end
        else if (wr && WB_SEL_I[0])
        begin
            if (WB_ADR_I == `COP_OFS_MODULATION_CONTROL_REG)
                mc_ff <= WB_DAT_I[13:0] & 14'h3FBF;
            if (WB_ADR_I == `COP_OFS_TRAPEN)
                te_ff <= WB_DAT_I[5:0];
        end
    end
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);
    sequence s_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    // two cycles under a condition, the first tickless, so no passive-level transfer lands
    sequence s_calm(c);
        c && !TMR_I.tick ##1 c;
    endsequence
    property p_ack_next;
        s_req |=> WB_ACK_O;
    endproperty
    property p_ack_pulse;
        WB_ACK_O |=> !WB_ACK_O;
    endproperty
    property p_ack_cause;
        WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I);
    endproperty
    property p_cmd_zero;
        rd && WB_ADR_I == `COP_OFS_CMD |-> WB_DAT_O == 32'h00000000;
    endproperty
    property p_unmap_zero;
        rd && WB_ADR_I > `COP_OFS_PSL |-> WB_DAT_O == 32'h00000000;
    endproperty
    property p_idle_passive;
        s_calm(mc_off) |=> $stable({HS_OUT_O, LS_OUT_O});
    endproperty
    property p_trap_passive;
        s_calm(te_ff == 6'h3F && MOD_I.trap) |=> $stable({HS_OUT_O, LS_OUT_O});
    endproperty
    property p_sec_follow;
        sec_only && !TMR_I.tick ##1 sec_only && $changed(MOD_I.sec_cmp)
            |=> {HS_OUT_O, LS_OUT_O} == ~$past({HS_OUT_O, LS_OUT_O});
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_cmd_zero: assert property (p_cmd_zero) else $error("command read not zero");
    a_unmap_zero: assert property (p_unmap_zero) else $error("unmapped read not zero");
    a_idle_passive: assert property (p_idle_passive) else $error("pins move, no source");
    a_trap_passive: assert property (p_trap_passive) else $error("pins move under trap");
    a_sec_follow: assert property (p_sec_follow) else $error("pins miss second compare");
endmodule : cop_path_checker

bind cop_path cop_path_checker #(.DT_W(DT_W)) u_chk (
    .CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .TMR_I(TMR_I), .MOD_I(MOD_I),
    .HS_OUT_O(HS_OUT_O), .LS_OUT_O(LS_OUT_O)
);

// File: tb/cop_path_tb_top.sv
// bench of the compare output path: bus tasks, timer ticks, pin checks
// assumes pins settle within three clocks of their cause
`timescale 1ns/1ps
`include "cop_cfg.svh"
module cop_path_tb_top;
    import cop_pkg::*;
    logic         clk;
    logic         rst_n;
    logic         cyc;
    logic         stb;
    logic         we;
    logic [3:0]   sel;
    logic [7:0]   adr;
    logic [31:0]  wd;
    logic [31:0]  rdat;
    logic [31:0]  rq;
    logic         ack;
    logic [2:0]   hs;
    logic [2:0]   ls;
    logic [7:0]   ovl;
    cop_tmr_t     tmr;
    cop_mod_src_t mods;
    int           error_cnt;
    int           compares;

    cop_path #(.DT_W(8)) dut (
        .CLK_SYS_I(clk), .RESET_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .TMR_I(tmr), .MOD_I(mods), .HS_OUT_O(hs), .LS_OUT_O(ls)
    );
    // overlap only judged while the passive level is 0
    cop_gate_drv u_drv (
        .clk_i(clk), .rst_n_i(rst_n), .hs_i(hs), .ls_i(ls), .off_lvl_i(1'b0),
        .overlap_cnt_o(ovl)
    );
    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, sel, adr, wd} <= {2'h3, w, 4'hF, a, d};
        @(posedge clk);
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        rq = rdat;
        if (n == 20)
            chk("ack", 32'h0, 32'h1);
        {cyc, stb} <= 2'h0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk("register", rq, e);
    endtask : rd
    task automatic pn(input logic [5:0] e);
        repeat (3) @(posedge clk);
        chk("pins", {26'h0, hs, ls}, {26'h0, e});
    endtask : pn
    // one primary timer clock
    task automatic tk(input logic r, input logic d, input logic [2:0] cm, input logic pm,
                      input logic om);
        @(posedge clk);
        tmr <= '{1'b1, r, d, pm, om, cm};
        @(posedge clk);
        tmr <= '{1'b0, r, d, 1'b0, 1'b0, 3'h0};
        repeat (3) @(posedge clk);
    endtask : tk
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    // main sequence
    initial
    begin
        {cyc, stb, we, sel, adr, wd} = '0;
        {tmr, mods, rst_n} = '0;
        error_cnt = 0;
        compares = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 7; a++)
            rd(8'(a * 4), 32'h0);
        wb(1'b1, `COP_OFS_DTC, 32'h00000103);
        rd(`COP_OFS_DTC, 32'h00000103);
        wb(1'b1, `COP_OFS_COMPARE_STATUS_REG, 32'h00001500);
        wb(1'b1, `COP_OFS_MODULATION_CONTROL_REG, 32'h0000003F);
        pn(6'h07);
        $display("test registers done");
        tk(1'b1, 1'b0, 3'h3, 1'b0, 1'b0);
        rd(`COP_OFS_COMPARE_STATUS_REG, 32'h00001513);
        pn(6'h14);
        tk(1'b1, 1'b0, 3'h0, 1'b0, 1'b0);
        tk(1'b1, 1'b0, 3'h0, 1'b0, 1'b0);
        pn(6'h14);
        tk(1'b1, 1'b0, 3'h0, 1'b0, 1'b0);
        pn(6'h1C);
        rd(`COP_OFS_COMPARE_STATUS_REG, 32'h00001503);
        tk(1'b1, 1'b1, 3'h1, 1'b0, 1'b0);
        pn(6'h14);
        wb(1'b1, `COP_OFS_CMD, 32'h00000001);
        pn(6'h15);
        rd(`COP_OFS_COMPARE_STATUS_REG, 32'h00001502);
        chk("overlap", {24'h0, ovl}, 32'h0);
        $display("test dead-time done");
        wb(1'b1, `COP_OFS_MODULATION_CONTROL_REG, 32'h0);
        wb(1'b1, `COP_OFS_PSL, 32'h0000003F);
        rd(`COP_OFS_PSL, 32'h0);
        pn(6'h00);
        wb(1'b1, `COP_OFS_CMD, 32'h00000002);
        rd(`COP_OFS_COMPARE_STATUS_REG, 32'h00001582);
        tk(1'b1, 1'b1, 3'h0, 1'b1, 1'b0);
        rd(`COP_OFS_PSL, 32'h0);
        tk(1'b1, 1'b0, 3'h0, 1'b1, 1'b0);
        rd(`COP_OFS_PSL, 32'h0000003F);
        rd(`COP_OFS_COMPARE_STATUS_REG, 32'h00001502);
        pn(6'h3F);
        wb(1'b1, `COP_OFS_PSL, 32'h0);
        wb(1'b1, `COP_OFS_CMD, 32'h00000002);
        tk(1'b1, 1'b1, 3'h0, 1'b0, 1'b1);
        rd(`COP_OFS_PSL, 32'h0);
        wb(1'b1, `COP_OFS_PSL, 32'h0000003F);
        tk(1'b0, 1'b0, 3'h0, 1'b0, 1'b0);
        rd(`COP_OFS_PSL, 32'h0000003F);
        wb(1'b1, `COP_OFS_CMD, 32'h00000002);
        rd(`COP_OFS_COMPARE_STATUS_REG, 32'h00001582);
        wb(1'b1, `COP_OFS_CMD, 32'h00000004);
        rd(`COP_OFS_COMPARE_STATUS_REG, 32'h00001502);
        $display("test passive levels done");
        wb(1'b1, `COP_OFS_MODULATION_CONTROL_REG, 32'h00003F00);
        @(posedge clk);
        mods <= '{1'b1, 6'h00, 1'b0};
        pn(6'h00);
        mods <= '{1'b0, 6'h00, 1'b0};
        pn(6'h3F);
        wb(1'b1, `COP_OFS_MODULATION_CONTROL_REG, 32'h00003F80);
        mods <= '{1'b1, 6'h15, 1'b0};
        pn(6'h07);
        wb(1'b1, `COP_OFS_TRAPEN, 32'h0000003F);
        mods <= '{1'b1, 6'h15, 1'b1};
        pn(6'h3F);
        mods <= '{1'b1, 6'h15, 1'b0};
        pn(6'h07);
        $display("test modulation done");
        end_sim();
    end
    // watchdog, far beyond the few hundred clocks the tests need
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        end_sim();
    end
endmodule : cop_path_tb_top
